// file: inc/frmtm_pkg.sv
`default_nettype none
package frmtm_pkg;
	localparam int unsigned REG_WIDTH = 64;
	localparam int unsigned FIELD_WIDTH = 8;
	localparam int unsigned FIELDS_PER_REG = 8;
	localparam int unsigned NUM_FIXED_REGS = 11;
	localparam int unsigned INDEX_WIDTH = 4;
	localparam int unsigned PADDR_WIDTH = 52;

	// Register indices presented on the model-specific register port
	localparam logic [3:0] IDX_FIXED_64K_BLOCK_0 = 4'h0;
	localparam logic [3:0] IDX_FIXED_16K_BLOCK_0 = 4'h1;
	localparam logic [3:0] IDX_FIXED_16K_BLOCK_1 = 4'h2;
	localparam logic [3:0] IDX_FIXED_4K_BLOCK_0 = 4'h3;
	localparam logic [3:0] IDX_FIXED_4K_BLOCK_7 = 4'hA;

	localparam logic [63:0] FIXED_REG_RESET = 64'h0000000000000000;
	localparam logic [63:0] READ_FAULT_DATA = 64'h0000000000000000;

	// Type field layout
	localparam int unsigned TYPE_CODE_LSB = 0;
	localparam int unsigned TYPE_CODE_MSB = 2;
	localparam int unsigned WRITE_TO_MEM_BIT = 3;
	localparam int unsigned READ_TO_MEM_BIT = 4;

	// Address decode of the lowest megabyte
	localparam int unsigned FIXED_TOP_BIT = 20;
	localparam logic [1:0] REGION_16K_SEL = 2'h2;
	localparam logic [1:0] REGION_4K_SEL = 2'h3;

	typedef enum logic [2:0] {
		FRMTM_UNCACHEABLE = 3'h0,
		FRMTM_WRITE_COMBINING = 3'h1,
		FRMTM_RESERVED_2 = 3'h2,
		FRMTM_RESERVED_3 = 3'h3,
		FRMTM_WRITETHROUGH = 3'h4,
		FRMTM_WRITE_PROTECT = 3'h5,
		FRMTM_WRITEBACK = 3'h6,
		FRMTM_RESERVED_7 = 3'h7
	} frmtm_type_t;

	typedef enum logic [1:0] {
		FRMTM_SRC_DISABLED = 2'h0,
		FRMTM_SRC_FIXED = 2'h1,
		FRMTM_SRC_VARIABLE = 2'h2,
		FRMTM_SRC_DEFAULT = 2'h3
	} frmtm_src_t;

	typedef struct packed {
		logic cacheable;
		logic write_combine_ok;
		logic speculative_ok;
		logic read_miss_alloc;
		logic write_miss_alloc;
		logic write_hit_to_memory;
		logic write_hit_invalidate;
		logic alloc_modified_ok;
		logic type_invalid;
	} frmtm_attr_t;

	typedef struct packed {
		logic read_to_memory_flag;
		logic write_to_memory_flag;
		logic io_range;
	} frmtm_ext_t;
endpackage : frmtm_pkg
`default_nettype wire

// file: sim/frmtm_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module frmtm_top_sva (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic MSR_WRITE_IN,
	input wire logic MSR_READ_IN,
	input wire logic [3:0] MSR_INDEX_IN,
	input wire logic MSR_ACK_OUT,
	input wire logic MSR_FAULT_OUT,
	input wire logic RANGE_TYPING_EN_IN,
	input wire logic LOOKUP_VALID_IN,
	input wire logic LOOKUP_VALID_OUT,
	input wire logic [2:0] MEM_TYPE_OUT,
	input wire logic [1:0] TYPE_SOURCE_OUT,
	input wire logic [8:0] ATTR_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	wire logic stb = MSR_WRITE_IN || MSR_READ_IN;
	wire logic lvo = LOOKUP_VALID_OUT;
	property p_ack; stb |=> MSR_ACK_OUT; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_noack; !stb |=> !MSR_ACK_OUT; endproperty
	a_noack: assert property (p_noack) else $error("ack without strobe");
	property p_fault; stb |=> MSR_FAULT_OUT == ($past(MSR_INDEX_IN) > 4'hA); endproperty
	a_fault: assert property (p_fault) else $error("fault wrong");
	property p_vld; LOOKUP_VALID_IN |=> lvo; endproperty
	a_vld: assert property (p_vld) else $error("lookup answer missing");
	property p_dis; LOOKUP_VALID_IN && !RANGE_TYPING_EN_IN |=> MEM_TYPE_OUT == 3'h0 && TYPE_SOURCE_OUT == 2'h0; endproperty
	a_dis: assert property (p_dis) else $error("disabled not uncacheable");
	property p_cach; lvo && ATTR_OUT[8] |-> MEM_TYPE_OUT inside {3'h4, 3'h5, 3'h6}; endproperty
	a_cach: assert property (p_cach) else $error("cacheable on wrong type");
	property p_inv; lvo |-> ATTR_OUT[0] == (MEM_TYPE_OUT inside {3'h2, 3'h3, 3'h7}); endproperty
	a_inv: assert property (p_inv) else $error("invalid flag wrong");
	property p_uc; lvo && MEM_TYPE_OUT == 3'h0 |-> ATTR_OUT[8:6] == 3'h0; endproperty
	a_uc: assert property (p_uc) else $error("uncacheable attrs wrong");
	property p_wc; lvo && MEM_TYPE_OUT == 3'h1 |-> ATTR_OUT[8:6] == 3'h3; endproperty
	a_wc: assert property (p_wc) else $error("write combining attrs wrong");
	property p_wt; lvo && MEM_TYPE_OUT == 3'h4 |-> !ATTR_OUT[4] && ATTR_OUT[3]; endproperty
	a_wt: assert property (p_wt) else $error("writethrough attrs wrong");
	c_fault: cover property (stb && MSR_INDEX_IN > 4'hA);
	c_fixed: cover property (lvo && TYPE_SOURCE_OUT == 2'h1);
	c_var: cover property (lvo && TYPE_SOURCE_OUT == 2'h2);
endmodule : frmtm_top_sva
`default_nettype wire

// file: sim/test_frmtm_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_frmtm_top;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, ten = 0, fen = 0, xen = 0, gcd = 0, vhit = 0, lv = 0;
	logic [3:0] idx = 4'h0;
	logic [63:0] wdata = 64'h0, rdata;
	logic [7:0] dtype = 8'h00, vtype = 8'h00;
	logic [51:0] la = 52'h0;
	logic ack, fault, lvo;
	logic [2:0] mt, ext;
	logic [1:0] src;
	logic [8:0] attr;
	int n_fail = 0, n_compared = 0, cyc = 0;
	always #4 clk = ~clk;
	frmtm_top u_dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .MSR_WRITE_IN(wr), .MSR_READ_IN(rd),
		.MSR_INDEX_IN(idx), .MSR_WDATA_IN(wdata), .MSR_RDATA_OUT(rdata), .MSR_ACK_OUT(ack),
		.MSR_FAULT_OUT(fault), .RANGE_TYPING_EN_IN(ten), .FIXED_RANGE_EN_IN(fen), .EXT_TYPE_EN_IN(xen),
		.GLOBAL_CACHE_DISABLE_IN(gcd), .DEFAULT_TYPE_IN(dtype), .VAR_RANGE_HIT_IN(vhit),
		.VAR_RANGE_TYPE_IN(vtype), .LOOKUP_VALID_IN(lv), .LOOKUP_ADDR_IN(la), .LOOKUP_VALID_OUT(lvo),
		.MEM_TYPE_OUT(mt), .TYPE_SOURCE_OUT(src), .ATTR_OUT(attr), .EXT_OUT(ext));
	task automatic complete_run();
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		cyc++;
		// Whole run needs about 1050 cycles
		if (cyc == 5000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic model_specific_register(input logic w, input logic [3:0] i, input logic [63:0] d);
		wr = w;
		rd = !w;
		idx = i;
		wdata = d;
		@(negedge clk);
		wr = 0;
		rd = 0;
		check(ack, 1'b1);
		check(fault, i > 4'hA);
		@(negedge clk);
	endtask : model_specific_register
	function automatic logic [8:0] attr_of(input logic [2:0] t);
		case (t)
			3'h0: return 9'h000;
			3'h1: return 9'h0C0;
			3'h4: return 9'h168;
			3'h5: return 9'h16C;
			3'h6: return 9'h172;
			default: return 9'h001;
		endcase
	endfunction : attr_of
	task automatic look(input logic [51:0] a, input logic [2:0] t, input logic [1:0] s);
		lv = 1;
		la = a;
		@(negedge clk);
		lv = 0;
		check(lvo, 1'b1);
		check(mt, t);
		check(src, s);
		check(attr, gcd ? attr_of(t) & 9'h0CD : attr_of(t));
		@(negedge clk);
	endtask : look
	task automatic t_regs();
		for (int i = 0; i < 16; i++) begin
			model_specific_register(1'b0, 4'(i), 64'h0);
			check(rdata, 64'h0);
			model_specific_register(1'b1, 4'(i), 64'h0123456789ABCDEF ^ 64'(i));
		end
		for (int i = 0; i < 16; i++) begin
			model_specific_register(1'b0, 4'(i), 64'h0);
			check(rdata, i < 11 ? 64'h0123456789ABCDEF ^ 64'(i) : 64'h0);
			model_specific_register(1'b1, 4'(i), 64'h0);
		end
	endtask : t_regs
	task automatic t_map();
		logic [51:0] b, sz;
		logic last;
		for (int r = 0; r < 11; r++) begin
			for (int f = 0; f < 8; f++) begin
				sz = r == 0 ? 52'h10000 : (r < 3 ? 52'h4000 : 52'h1000);
				b = r == 0 ? 52'h0 : (r < 3 ? 52'h80000 + 52'(r - 1) * 52'h20000 : 52'hC0000 + 52'(r - 3) * 52'h8000);
				b = b + 52'(f) * sz;
				last = r == 10 && f == 7;
				model_specific_register(1'b1, 4'(r), {8{8'h04}} | (64'h02 << (8 * f)));
				look(b, 3'h6, 2'h1);
				look(b + sz - 52'h1, 3'h6, 2'h1);
				look(b + sz, f < 7 ? 3'h4 : 3'h0, last ? 2'h3 : 2'h1);
				model_specific_register(1'b1, 4'(r), 64'h0);
			end
		end
	endtask : t_map
	task automatic t_codes();
		model_specific_register(1'b1, 4'h0, 64'h0706050403020100);
		for (int f = 0; f < 8; f++)
			look(52'(f) << 16, 3'(f), 2'h1);
		gcd = 1;
		look(52'h60000, 3'h6, 2'h1);
		ten = 0;
		gcd = 0;
		look(52'h60000, 3'h0, 2'h0);
		ten = 1;
		model_specific_register(1'b1, 4'h0, 64'hEEF6);
		xen = 1;
		look(52'h0, 3'h6, 2'h1);
		check(ext[2:1], 2'h2);
		look(52'h10000, 3'h6, 2'h1);
		check(ext[2:1], 2'h1);
		xen = 0;
		look(52'h0, 3'h6, 2'h1);
		check(ext, 3'h0);
	endtask : t_codes
	task automatic t_var();
		fen = 0;
		xen = 1;
		vhit = 1;
		vtype = 8'h1E;
		look(52'h0, 3'h6, 2'h2);
		check(ext, 3'h0);
		vhit = 0;
		dtype = 8'h05;
		look(52'h0, 3'h5, 2'h3);
		fen = 1;
		vhit = 1;
		look(52'h100000, 3'h6, 2'h2);
	endtask : t_var
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1;
		ten = 1;
		fen = 1;
		t_regs();
		t_map();
		t_codes();
		t_var();
		complete_run();
	end
endmodule : test_frmtm_top
bind frmtm_top frmtm_top_sva u_sva (.CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN),
	.MSR_WRITE_IN(MSR_WRITE_IN), .MSR_READ_IN(MSR_READ_IN), .MSR_INDEX_IN(MSR_INDEX_IN),
	.MSR_ACK_OUT(MSR_ACK_OUT), .MSR_FAULT_OUT(MSR_FAULT_OUT), .RANGE_TYPING_EN_IN(RANGE_TYPING_EN_IN),
	.LOOKUP_VALID_IN(LOOKUP_VALID_IN), .LOOKUP_VALID_OUT(LOOKUP_VALID_OUT), .MEM_TYPE_OUT(MEM_TYPE_OUT),
	.TYPE_SOURCE_OUT(TYPE_SOURCE_OUT), .ATTR_OUT(ATTR_OUT));
`default_nettype wire

// file: src/frmtm_top.sv
// Operation
// - Memory type comes from bits 2..0 of a type field in both encodings.
// - Extended encoding: bits 7..5 reserved, bit 4 read flag, bit 3 write flag.
// - Only fixed registers honour extended encoding; variable ones use standard.
// - Standard type values apply unless extended encoding is explicitly enabled.
// - Code zero is uncacheable, no write combining, no speculative access.
// - Code four allocates on read miss only; write hits update cache and memory.
// - Code five allocates on read miss; writes go to memory; write hits invalidate.
// - Code six read miss may allocate any state; write miss allocates modified.
// - Mechanism disabled makes all memory uncacheable regardless of cache disable.
// - Only addresses given a cacheable type by the registers are cached.
// - Fixed ranges cover only the lowest megabyte; variable ranges anywhere.
// - Addresses no range covers take the software-selected default type.
// - Each register is 64 bits, read and written by the msr instructions.
// - Eight byte fields per register; byte zero types the lowest sub-range.
// - The lowest megabyte splits into 88 ranges, each with its own field.
// - Lowest 512 Kbytes: eight 64-Kbyte ranges in one register.
// - Next 256 Kbytes: sixteen 16-Kbyte ranges in two registers.
// - Top 256 Kbytes: sixty-four 4-Kbyte ranges in eight registers.
// - Extended encoding lets a fixed register act as an I/O range register.
`timescale 1ns/1ps
`default_nettype none
module frmtm_top (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	// Model-specific register port
	input wire logic MSR_WRITE_IN,
	input wire logic MSR_READ_IN,
	input wire logic [frmtm_pkg::INDEX_WIDTH-1:0] MSR_INDEX_IN,
	input wire logic [frmtm_pkg::REG_WIDTH-1:0] MSR_WDATA_IN,
	output logic [frmtm_pkg::REG_WIDTH-1:0] MSR_RDATA_OUT,
	output logic MSR_ACK_OUT,
	output logic MSR_FAULT_OUT,
	// Controls held elsewhere in the core
	input wire logic RANGE_TYPING_EN_IN,
	input wire logic FIXED_RANGE_EN_IN,
	input wire logic EXT_TYPE_EN_IN,
	input wire logic GLOBAL_CACHE_DISABLE_IN,
	input wire logic [frmtm_pkg::FIELD_WIDTH-1:0] DEFAULT_TYPE_IN,
	// Result of the variable-range match done outside this block
	input wire logic VAR_RANGE_HIT_IN,
	input wire logic [frmtm_pkg::FIELD_WIDTH-1:0] VAR_RANGE_TYPE_IN,
	// Lookup
	input wire logic LOOKUP_VALID_IN,
	input wire logic [frmtm_pkg::PADDR_WIDTH-1:0] LOOKUP_ADDR_IN,
	output logic LOOKUP_VALID_OUT,
	output logic [2:0] MEM_TYPE_OUT,
	output logic [1:0] TYPE_SOURCE_OUT,
	output logic [8:0] ATTR_OUT,
	output logic [2:0] EXT_OUT
);

	logic [frmtm_pkg::REG_WIDTH-1:0] fixed_q [frmtm_pkg::NUM_FIXED_REGS];
	logic index_ok;
	logic [3:0] sel_reg;
	logic [2:0] sel_field;
	logic in_low_mb;
	logic [7:0] fixed_field;
	logic [7:0] chosen_field;
	logic ext_active;
	frmtm_pkg::frmtm_src_t src;
	frmtm_pkg::frmtm_type_t code;
	frmtm_pkg::frmtm_attr_t attr;
	frmtm_pkg::frmtm_ext_t ext;
	logic [frmtm_pkg::REG_WIDTH-1:0] rdata_d;

	assign index_ok = (MSR_INDEX_IN <= frmtm_pkg::IDX_FIXED_4K_BLOCK_7);

	// Storage: each fixed register kept whole so software reads back what it wrote
	genvar gi;
	generate
		for (gi = 0; gi < frmtm_pkg::NUM_FIXED_REGS; gi++) begin : g_fixed
			always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
				if (!RESET_N_IN) begin
					fixed_q[gi] <= frmtm_pkg::FIXED_REG_RESET;
				end else if (MSR_WRITE_IN && MSR_INDEX_IN == 4'(gi)) begin
					fixed_q[gi] <= MSR_WDATA_IN;
				end
			end
		end
	endgenerate

	always_comb begin
		rdata_d = frmtm_pkg::READ_FAULT_DATA;
		if (index_ok) begin
			rdata_d = fixed_q[MSR_INDEX_IN];
		end
	end

	// Read data and acknowledge; unmapped indices fault and read as zero
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			MSR_RDATA_OUT <= frmtm_pkg::READ_FAULT_DATA;
		end else if (MSR_READ_IN) begin
			MSR_RDATA_OUT <= rdata_d;
		end
	end

	// Every strobe is answered, mapped or not, so software never waits forever
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			MSR_ACK_OUT <= 1'b0;
		end else begin
			MSR_ACK_OUT <= MSR_READ_IN | MSR_WRITE_IN;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			MSR_FAULT_OUT <= 1'b0;
		end else begin
			MSR_FAULT_OUT <= (MSR_READ_IN | MSR_WRITE_IN) & ~index_ok;
		end
	end

	// Region decode of the lowest megabyte
	assign in_low_mb = ~|LOOKUP_ADDR_IN[frmtm_pkg::PADDR_WIDTH-1:frmtm_pkg::FIXED_TOP_BIT];

	always_comb begin
		sel_reg = frmtm_pkg::IDX_FIXED_64K_BLOCK_0;
		sel_field = LOOKUP_ADDR_IN[18:16];
		if (LOOKUP_ADDR_IN[19:18] == frmtm_pkg::REGION_16K_SEL) begin
			sel_reg = frmtm_pkg::IDX_FIXED_16K_BLOCK_0 + {3'h0, LOOKUP_ADDR_IN[17]};
			sel_field = LOOKUP_ADDR_IN[16:14];
		end else if (LOOKUP_ADDR_IN[19:18] == frmtm_pkg::REGION_4K_SEL) begin
			sel_reg = frmtm_pkg::IDX_FIXED_4K_BLOCK_0 + {1'b0, LOOKUP_ADDR_IN[17:15]};
			sel_field = LOOKUP_ADDR_IN[14:12];
		end
	end

	// Byte zero types the lowest sub-range, each field its own range
	assign fixed_field = fixed_q[sel_reg][{sel_field, 3'h0} +: frmtm_pkg::FIELD_WIDTH];

	// Source priority: disabled, fixed, variable, default
	always_comb begin
		if (!RANGE_TYPING_EN_IN) begin
			src = frmtm_pkg::FRMTM_SRC_DISABLED;
		end else if (FIXED_RANGE_EN_IN && in_low_mb) begin
			src = frmtm_pkg::FRMTM_SRC_FIXED;
		end else if (VAR_RANGE_HIT_IN) begin
			src = frmtm_pkg::FRMTM_SRC_VARIABLE;
		end else begin
			src = frmtm_pkg::FRMTM_SRC_DEFAULT;
		end
	end

	// Disabled source reads as an all-zero field, which decodes as uncacheable
	always_comb begin
		case (src)
			frmtm_pkg::FRMTM_SRC_FIXED: begin
				chosen_field = fixed_field;
			end
			frmtm_pkg::FRMTM_SRC_VARIABLE: begin
				chosen_field = VAR_RANGE_TYPE_IN;
			end
			frmtm_pkg::FRMTM_SRC_DEFAULT: begin
				chosen_field = DEFAULT_TYPE_IN;
			end
			default: begin
				chosen_field = 8'h00;
			end
		endcase
	end

	// Type code always from the low three bits, reserved upper bits ignored
	assign code = frmtm_pkg::frmtm_type_t'(chosen_field[frmtm_pkg::TYPE_CODE_MSB:frmtm_pkg::TYPE_CODE_LSB]);

	// Flags exist only for fixed fields with the extension switched on
	assign ext_active = EXT_TYPE_EN_IN && (src == frmtm_pkg::FRMTM_SRC_FIXED);

	always_comb begin
		ext.read_to_memory_flag = ext_active & chosen_field[frmtm_pkg::READ_TO_MEM_BIT];
		ext.write_to_memory_flag = ext_active & chosen_field[frmtm_pkg::WRITE_TO_MEM_BIT];
		ext.io_range = ext.read_to_memory_flag | ext.write_to_memory_flag;
	end

	always_comb begin
		attr = '0;
		// Every field spelled out per type so a missing bit stands out in reading
		case (code)
			frmtm_pkg::FRMTM_UNCACHEABLE: begin
				attr.cacheable = 1'b0;
				attr.write_combine_ok = 1'b0;
				attr.speculative_ok = 1'b0;
				attr.read_miss_alloc = 1'b0;
				attr.write_miss_alloc = 1'b0;
				attr.write_hit_to_memory = 1'b0;
				attr.write_hit_invalidate = 1'b0;
				attr.alloc_modified_ok = 1'b0;
				attr.type_invalid = 1'b0;
			end
			frmtm_pkg::FRMTM_WRITE_COMBINING: begin
				attr.cacheable = 1'b0;
				attr.write_combine_ok = 1'b1;
				attr.speculative_ok = 1'b1;
				attr.read_miss_alloc = 1'b0;
				attr.write_miss_alloc = 1'b0;
				attr.write_hit_to_memory = 1'b0;
				attr.write_hit_invalidate = 1'b0;
				attr.alloc_modified_ok = 1'b0;
				attr.type_invalid = 1'b0;
			end
			frmtm_pkg::FRMTM_WRITETHROUGH: begin
				attr.cacheable = 1'b1;
				attr.write_combine_ok = 1'b0;
				attr.speculative_ok = 1'b1;
				attr.read_miss_alloc = 1'b1;
				attr.write_miss_alloc = 1'b0;
				attr.write_hit_to_memory = 1'b1;
				attr.write_hit_invalidate = 1'b0;
				attr.alloc_modified_ok = 1'b0;
				attr.type_invalid = 1'b0;
			end
			frmtm_pkg::FRMTM_WRITE_PROTECT: begin
				attr.cacheable = 1'b1;
				attr.write_combine_ok = 1'b0;
				attr.speculative_ok = 1'b1;
				attr.read_miss_alloc = 1'b1;
				attr.write_miss_alloc = 1'b0;
				attr.write_hit_to_memory = 1'b1;
				attr.write_hit_invalidate = 1'b1;
				attr.alloc_modified_ok = 1'b0;
				attr.type_invalid = 1'b0;
			end
			frmtm_pkg::FRMTM_WRITEBACK: begin
				attr.cacheable = 1'b1;
				attr.write_combine_ok = 1'b0;
				attr.speculative_ok = 1'b1;
				attr.read_miss_alloc = 1'b1;
				attr.write_miss_alloc = 1'b1;
				attr.write_hit_to_memory = 1'b0;
				attr.write_hit_invalidate = 1'b0;
				attr.alloc_modified_ok = 1'b1;
				attr.type_invalid = 1'b0;
			end
			default: begin
				// Reserved codes are flagged and never cached
				attr.cacheable = 1'b0;
				attr.write_combine_ok = 1'b0;
				attr.speculative_ok = 1'b0;
				attr.read_miss_alloc = 1'b0;
				attr.write_miss_alloc = 1'b0;
				attr.write_hit_to_memory = 1'b0;
				attr.write_hit_invalidate = 1'b0;
				attr.alloc_modified_ok = 1'b0;
				attr.type_invalid = 1'b1;
			end
		endcase
		// Cache disable only removes caching; it never grants it
		if (GLOBAL_CACHE_DISABLE_IN) begin
			attr.cacheable = 1'b0;
			attr.read_miss_alloc = 1'b0;
			attr.write_miss_alloc = 1'b0;
			attr.alloc_modified_ok = 1'b0;
		end
	end

	// Registered answer, one cycle after the lookup is presented
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			LOOKUP_VALID_OUT <= 1'b0;
		end else begin
			LOOKUP_VALID_OUT <= LOOKUP_VALID_IN;
		end
	end

	// Answers hold between lookups so a slow consumer can still read them
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			MEM_TYPE_OUT <= 3'h0;
		end else if (LOOKUP_VALID_IN) begin
			MEM_TYPE_OUT <= code;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			TYPE_SOURCE_OUT <= 2'h0;
		end else if (LOOKUP_VALID_IN) begin
			TYPE_SOURCE_OUT <= src;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ATTR_OUT <= 9'h000;
		end else if (LOOKUP_VALID_IN) begin
			ATTR_OUT <= attr;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			EXT_OUT <= 3'h0;
		end else if (LOOKUP_VALID_IN) begin
			EXT_OUT <= ext;
		end
	end

endmodule : frmtm_top
`default_nettype wire
